// ==== core/scs_clock_select.sv ====
// Per-channel clock source selection, divider, slot windows and clock pin control
//
// Function
// - Eight clock modes chosen by mode field
// - PLL reference from divider, factor 1..2048
// - System clock follows selected transmit clock
// - Direction bit makes transmit clock pin drive in modes 3, 4, 5 and 7, and in modes 2 and 6 only with divider/16 selected
// - Mode 0: separate external receive, transmit clocks
// - Mode 1: shared clock, strobes gate directions
// - Mode 2: PLL receive; transmit pin or divider/16
// - Mode 3: PLL clocks both directions, pin output
// - Mode 4: oscillator clocks both directions directly
// - Mode 5: frame sync, windows 1..256 bits
// - Slot position: 64 slots plus 0..7 shift
// - Window opens 1..512 periods after sync
// - Transmit pin low during transmit window
// - Request-to-send drops early at window end
// - Clear-to-send stops transmitter at once
// - Mode 6: as mode 2, oscillator feeds divider
// - Mode 7: as mode 3, oscillator feeds divider
// - Strobes enable or disable single windows
// - Divider output is sixteen times bit rate
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "scs_consts.svh"

module scs_clock_select (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Register port
  input  wire logic [2:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [7:0]                   reg_rdata,
  // Clock and strobe pins
  input  wire logic                    rxc_pin,
  input  wire logic                    txc_pin_in,
  output logic                         txc_pin_out,
  output logic                         txc_pin_oe,
  input  wire logic                    aux_pin,
  input  wire logic                    osc_pin,
  input  wire logic                    rx_strobe_pin,
  input  wire logic                    tx_strobe_pin,
  input  wire logic                    cts_pin,
  // Transmitter handshake
  input  wire logic                    rts_request,
  input  wire logic                    flag_penult,
  output logic                         rts,
  // Clock ticks to the channel
  output scs_pkg::scs_clk_out_type     clk_out
);

  scs_pkg::scs_state_type q;
  scs_pkg::scs_state_type d;

  logic [6:0]  pins;
  logic [6:0]  rise;
  logic        rx_window;
  logic        rx_closing;
  logic        tx_window;
  logic        tx_closing;
  logic        slot_tick;
  logic        fsync;
  logic        brg_src;
  logic        brg_tick;
  logic        pll_tick;
  logic [10:0] brg_reload;
  logic [8:0]  rx_slot_pos;
  logic [8:0]  tx_slot_pos;

  // Divide factor 1, 2, 4, 6 .. 2048 from an 11-bit setting; settings above 1024 alias
  function automatic logic [10:0] brg_reload_of(input logic [10:0] setting);
    logic [11:0] twice;
    twice = {setting, 1'b0} - 12'h001;
    if (setting == `SCS_BRG_ZERO) begin
      brg_reload_of = `SCS_BRG_ZERO;
    end else begin
      brg_reload_of = twice[10:0];
    end
  endfunction

  // Modes whose divider runs from the crystal oscillator
  function automatic logic brg_from_osc(input scs_pkg::scs_mode_type m);
    brg_from_osc = (m == scs_pkg::SCS_MODE_OSC_PLL_RX) ||
                   (m == scs_pkg::SCS_MODE_OSC_PLL_BOTH);
  endfunction

  // Modes that use the divider and recovered clock
  function automatic logic uses_pll(input scs_pkg::scs_mode_type m);
    uses_pll = (m == scs_pkg::SCS_MODE_PLL_RX) || (m == scs_pkg::SCS_MODE_PLL_BOTH) ||
               (m == scs_pkg::SCS_MODE_OSC_PLL_RX) || (m == scs_pkg::SCS_MODE_OSC_PLL_BOTH);
  endfunction

  // Pins gathered for the synchroniser, in index order
  assign pins = {tx_strobe_pin, rx_strobe_pin, cts_pin, osc_pin, aux_pin, txc_pin_in, rxc_pin};

  // Rising edges come from the second and third stages only
  assign rise = q.s2 & ~q.s3;

  // Slot bit clock comes from the receive clock pin, frame sync from the aux pin in slot mode
  assign slot_tick = rise[`SCS_PIN_RXC];
  assign fsync     = rise[`SCS_PIN_AUX] && (q.mode == scs_pkg::SCS_MODE_SLOT);

  // Nine-bit slot position: slot and upper shift bits over the separate shift lsb
  assign rx_slot_pos = {q.rx_pos, q.cfg_two[`SCS_BIT_RECEIVE_SHIFT_LSB]};
  assign tx_slot_pos = {q.tx_pos, q.cfg_two[`SCS_BIT_TRANSMIT_SHIFT_LSB]};

  // Divider source and reload
  assign brg_src    = brg_from_osc(q.mode) ? rise[`SCS_PIN_OSC] : rise[`SCS_PIN_RXC];
  assign brg_reload = brg_reload_of({q.cfg_two[`SCS_DIV_HI_MSB:`SCS_DIV_HI_LSB], q.div_lo});
  assign brg_tick   = uses_pll(q.mode) && brg_src && (q.brg_cnt == `SCS_BRG_ZERO);
  // Phase tracking is outside this block: the recovered clock runs at its nominal rate
  assign pll_tick   = brg_tick && (q.pll_cnt == `SCS_PLL_LAST);

  // Receive window timer
  scs_slot_window u_rx_slot (
    .clk      (clk),
    .rst      (rst),
    .bit_tick (slot_tick),
    .fsync    (fsync),
    .pos      (rx_slot_pos),
    .width    (q.rx_width),
    .window   (rx_window),
    .closing  (rx_closing)
  );

  // Transmit window timer
  scs_slot_window u_tx_slot (
    .clk      (clk),
    .rst      (rst),
    .bit_tick (slot_tick),
    .fsync    (fsync),
    .pos      (tx_slot_pos),
    .width    (q.tx_width),
    .window   (tx_window),
    .closing  (tx_closing)
  );

  // Next state of the whole block
  always_comb begin
    d = q;

    // Two stages before any logic, third stage only for edge detection
    d.s1 = pins;
    d.s2 = q.s1;
    d.s3 = q.s2;

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        `SCS_ADDR_CFG_ONE: begin
          d.mode = scs_pkg::scs_mode_type'(reg_wdata[`SCS_MODE_MSB:`SCS_MODE_LSB]);
        end
        `SCS_ADDR_CFG_TWO: begin
          d.cfg_two = reg_wdata;
        end
        `SCS_ADDR_DIV: begin
          d.div_lo = reg_wdata;
        end
        `SCS_ADDR_RX_WIDTH: begin
          d.rx_width = reg_wdata;
        end
        `SCS_ADDR_TX_WIDTH: begin
          d.tx_width = reg_wdata;
        end
        `SCS_ADDR_RX_POS: begin
          d.rx_pos = reg_wdata;
        end
        `SCS_ADDR_TX_POS: begin
          d.tx_pos = reg_wdata;
        end
        default: begin
          d.rdata = q.rdata;                                // Status is read only
        end
      endcase
    end

    // Read data stand for exactly one cycle after the strobe
    d.rdata = `SCS_RST_REG;
    if (reg_rd) begin
      case (reg_addr)
        `SCS_ADDR_CFG_ONE:  d.rdata = {5'h00, q.mode};
        `SCS_ADDR_CFG_TWO:  d.rdata = q.cfg_two;
        `SCS_ADDR_DIV:      d.rdata = q.div_lo;
        `SCS_ADDR_RX_WIDTH: d.rdata = q.rx_width;
        `SCS_ADDR_TX_WIDTH: d.rdata = q.tx_width;
        `SCS_ADDR_RX_POS:   d.rdata = q.rx_pos;
        `SCS_ADDR_TX_POS:   d.rdata = q.tx_pos;
        `SCS_ADDR_STATUS:   d.rdata = {q.s2[`SCS_PIN_CTS], q.rts, tx_window, rx_window,
                                       q.txc_oe, q.mode};
        default:            d.rdata = `SCS_RST_REG;
      endcase
    end

    // Divider counts down on its source edge and reloads at zero
    if (uses_pll(q.mode) && brg_src) begin
      if (q.brg_cnt == `SCS_BRG_ZERO) begin
        d.brg_cnt = brg_reload;
      end else begin
        d.brg_cnt = q.brg_cnt - 11'h001;
      end
    end

    // Recovered clock and divider/16 share one sixteen-step counter
    if (brg_tick) begin
      d.pll_cnt = q.pll_cnt + 4'h1;
    end

    // Receive clock source by mode
    case (q.mode)
      scs_pkg::SCS_MODE_EXT,
      scs_pkg::SCS_MODE_STROBE,
      scs_pkg::SCS_MODE_SLOT: begin
        d.clk_out.rx_tick = rise[`SCS_PIN_RXC];
      end
      scs_pkg::SCS_MODE_OSC: begin
        d.clk_out.rx_tick = rise[`SCS_PIN_OSC];
      end
      default: begin
        d.clk_out.rx_tick = pll_tick;
      end
    endcase

    // Transmit clock source by mode
    case (q.mode)
      scs_pkg::SCS_MODE_EXT: begin
        d.clk_out.tx_tick = rise[`SCS_PIN_TXC];
      end
      scs_pkg::SCS_MODE_STROBE,
      scs_pkg::SCS_MODE_SLOT: begin
        d.clk_out.tx_tick = rise[`SCS_PIN_RXC];
      end
      scs_pkg::SCS_MODE_PLL_RX,
      scs_pkg::SCS_MODE_OSC_PLL_RX: begin
        // Divider/16 equals the nominal recovered clock here
        d.clk_out.tx_tick = q.cfg_two[`SCS_BIT_TSS] ? pll_tick
                                                    : rise[`SCS_PIN_TXC];
      end
      scs_pkg::SCS_MODE_PLL_BOTH,
      scs_pkg::SCS_MODE_OSC_PLL_BOTH: begin
        d.clk_out.tx_tick = pll_tick;
      end
      scs_pkg::SCS_MODE_OSC: begin
        d.clk_out.tx_tick = rise[`SCS_PIN_OSC];
      end
      default: begin
        d.clk_out.tx_tick = 1'b0;
      end
    endcase

    // No other clock feeds the channel's internal logic
    d.clk_out.sys_tick = d.clk_out.tx_tick;

    // Window strobes follow their pins between windows and freeze inside one
    if (!rx_window) begin
      d.rx_gate = q.s2[`SCS_PIN_RXS];
    end
    if (!tx_window) begin
      d.tx_gate = q.s2[`SCS_PIN_TXS];
    end

    // Direction gates by mode
    case (q.mode)
      scs_pkg::SCS_MODE_STROBE: begin
        d.clk_out.rx_en = q.s2[`SCS_PIN_AUX];
        d.clk_out.tx_en = q.s2[`SCS_PIN_TXC];
      end
      scs_pkg::SCS_MODE_SLOT: begin
        d.clk_out.rx_en = rx_window && d.rx_gate;
        // Clear-to-send is watched on every cycle inside a window; between windows the window alone holds the transmitter off
        d.clk_out.tx_en = tx_window && d.tx_gate && q.s2[`SCS_PIN_CTS];
      end
      default: begin
        d.clk_out.rx_en = 1'b1;
        d.clk_out.tx_en = 1'b1;
      end
    endcase

    // Transmit clock pin: drives only where the mode defines an output
    case (q.mode)
      scs_pkg::SCS_MODE_PLL_RX,
      scs_pkg::SCS_MODE_OSC_PLL_RX: begin
        d.txc_oe  = q.cfg_two[`SCS_BIT_TIO] && q.cfg_two[`SCS_BIT_TSS];
        d.txc_out = d.clk_out.tx_tick;
      end
      scs_pkg::SCS_MODE_PLL_BOTH,
      scs_pkg::SCS_MODE_OSC_PLL_BOTH,
      scs_pkg::SCS_MODE_OSC: begin
        d.txc_oe  = q.cfg_two[`SCS_BIT_TIO];
        d.txc_out = d.clk_out.tx_tick;
      end
      scs_pkg::SCS_MODE_SLOT: begin
        d.txc_oe  = q.cfg_two[`SCS_BIT_TIO];
        d.txc_out = !tx_window;
      end
      default: begin
        // Pin is an input in these modes, so it never fights the outside clock
        d.txc_oe  = 1'b0;
        d.txc_out = 1'b0;
      end
    endcase

    // Request-to-send; in slot mode it drops after the second-last flag bit
    // when that bit closes a window, and stays down until the request ends
    if (!rts_request) begin
      d.rts      = 1'b0;
      d.rts_hold = 1'b0;
    end else if ((q.mode == scs_pkg::SCS_MODE_SLOT) && slot_tick && tx_closing &&
                 flag_penult) begin
      d.rts      = 1'b0;
      d.rts_hold = 1'b1;
    end else begin
      d.rts      = !q.rts_hold;
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q         <= '0;
      q.mode    <= scs_pkg::scs_mode_type'(`SCS_RST_MODE);
      q.cfg_two <= `SCS_RST_REG;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata   = q.rdata;
  assign txc_pin_out = q.txc_out;
  assign txc_pin_oe  = q.txc_oe;
  assign rts         = q.rts;
  assign clk_out     = q.clk_out;

endmodule // scs_clock_select

// ==== shared/scs_consts.svh ====
// Register offsets, field positions, reset values and counts of the clock select block
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH

// Register offsets (word index on the plain register port)
`define SCS_ADDR_CFG_ONE    3'h0
`define SCS_ADDR_CFG_TWO    3'h1
`define SCS_ADDR_DIV        3'h2
`define SCS_ADDR_RX_WIDTH   3'h3
`define SCS_ADDR_TX_WIDTH   3'h4
`define SCS_ADDR_RX_POS     3'h5
`define SCS_ADDR_TX_POS     3'h6
`define SCS_ADDR_STATUS     3'h7

// Field positions in channel_config_one
`define SCS_MODE_LSB        0
`define SCS_MODE_MSB        2

// Field positions in channel_config_two
`define SCS_BIT_TSS         0
`define SCS_BIT_TIO         1
`define SCS_BIT_RECEIVE_SHIFT_LSB        2
`define SCS_BIT_TRANSMIT_SHIFT_LSB        3
`define SCS_DIV_HI_LSB      4
`define SCS_DIV_HI_MSB      6

// Reset values
`define SCS_RST_REG         8'h00
`define SCS_RST_MODE        3'h0

// Divider and recovered clock counts
`define SCS_PLL_LAST        4'hf
`define SCS_BRG_ZERO        11'h000

// Pin index in the synchroniser vectors
`define SCS_PIN_RXC         0
`define SCS_PIN_TXC         1
`define SCS_PIN_AUX         2
`define SCS_PIN_OSC         3
`define SCS_PIN_CTS         4
`define SCS_PIN_RXS         5
`define SCS_PIN_TXS         6
`define SCS_PIN_COUNT       7

`endif

// ==== shared/scs_pkg.sv ====
// Types of the serial channel clock select block
package scs_pkg;

  // Clocking modes as software encodes them
  typedef enum logic [2:0] {
    SCS_MODE_EXT          = 3'h0,
    SCS_MODE_STROBE       = 3'h1,
    SCS_MODE_PLL_RX       = 3'h2,
    SCS_MODE_PLL_BOTH     = 3'h3,
    SCS_MODE_OSC          = 3'h4,
    SCS_MODE_SLOT         = 3'h5,
    SCS_MODE_OSC_PLL_RX   = 3'h6,
    SCS_MODE_OSC_PLL_BOTH = 3'h7
  } scs_mode_type;

  // Clock ticks and gates handed to the serial channel
  typedef struct packed {
    logic rx_tick;
    logic tx_tick;
    logic sys_tick;
    logic rx_en;
    logic tx_en;
  } scs_clk_out_type;

  // State of one time-slot window
  typedef struct packed {
    logic [9:0] count;
    logic       armed;
    logic       open;
    logic [8:0] left;
  } scs_slot_type;

  // Whole state of the clock select top
  typedef struct packed {
    logic [6:0]      s1;
    logic [6:0]      s2;
    logic [6:0]      s3;
    scs_mode_type    mode;
    logic [7:0]      cfg_two;
    logic [7:0]      div_lo;
    logic [7:0]      rx_width;
    logic [7:0]      tx_width;
    logic [7:0]      rx_pos;
    logic [7:0]      tx_pos;
    logic [10:0]     brg_cnt;
    logic [3:0]      pll_cnt;
    logic            rx_gate;
    logic            tx_gate;
    logic            rts;
    logic            rts_hold;
    scs_clk_out_type clk_out;
    logic            txc_out;
    logic            txc_oe;
    logic [7:0]      rdata;
  } scs_state_type;

endpackage

// ==== core/scs_slot_window.sv ====
// Time-slot window timer measured in bit periods from the frame sync
`timescale 1ns/10ps
`include "scs_consts.svh"

module scs_slot_window (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Timing
  input  wire logic       bit_tick,
  input  wire logic       fsync,
  // Programming
  input  wire logic [8:0] pos,
  input  wire logic [7:0] width,
  // Window
  output logic            window,
  output logic            closing
);

  scs_pkg::scs_slot_type q;
  scs_pkg::scs_slot_type d;

  // Count bit periods, open after pos+1 of them, hold open width+1 of them
  always_comb begin
    d = q;
    if (fsync) begin
      d.count = 10'h000;
      d.armed = 1'b1;
      d.open  = 1'b0;
    end else if (bit_tick) begin
      if (q.open) begin
        d.left = q.left - 9'h001;
        if (q.left == 9'h001) begin
          d.open = 1'b0;
        end
      end
      if (q.armed) begin
        d.count = q.count + 10'h001;
        if (d.count == ({1'b0, pos} + 10'h001)) begin
          d.open  = 1'b1;
          d.left  = {1'b0, width} + 9'h001;
          d.armed = 1'b0;
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign window  = q.open;
  assign closing = q.open && (q.left == 9'h001);             // Last bit of the window

endmodule // scs_slot_window

// ==== tb/scs_clock_select_monitor.sv ====
// Port checks for the clock select block
`timescale 1ns/10ps

module scs_clock_select_monitor (
  // Clock and reset
  input wire logic                     clk,
  input wire logic                     rst,
  // Register port
  input wire logic [2:0]               reg_addr,
  input wire logic [7:0]               reg_wdata,
  input wire logic                     reg_wr,
  input wire logic                     reg_rd,
  input wire logic [7:0]               reg_rdata,
  // Pins and handshake
  input wire logic                     rxc_pin,
  input wire logic                     txc_pin_out,
  input wire logic                     txc_pin_oe,
  input wire logic                     cts_pin,
  input wire logic                     rts_request,
  input wire logic                     rts,
  input wire scs_pkg::scs_clk_out_type clk_out
);
  logic [2:0] mode_q;
  logic       tio_q;
  logic [1:0] age_q;
  logic       is5;
  logic       plain;

  // Shadow of mode and pin direction; age masks the first edges after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= 3'h0;
      tio_q  <= 1'b0;
      age_q  <= 2'h0;
    end else begin
      if (reg_wr && reg_addr == 3'h0) mode_q <= reg_wdata[2:0];
      if (reg_wr && reg_addr == 3'h1) tio_q <= reg_wdata[1];
      if (age_q != 2'h3) age_q <= age_q + 2'h1;
    end
  end

  // Slot mode, and modes without strobes or windows
  assign is5   = (mode_q == 3'h5);
  assign plain = (mode_q != 3'h5) && (mode_q != 3'h1) && (age_q == 2'h3);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Clear-to-send held off long enough to pass the synchroniser
  sequence cts_gone;
    (is5 && !cts_pin) [*5];
  endsequence

  chk_rd_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  chk_rd_mode_back: assert property (reg_rd && (reg_addr == 3'h0 || reg_addr == 3'h7) |=> reg_rdata[2:0] == mode_q)
    else $error("mode readback differs from last written mode");
  chk_sys_follow_tx: assert property (clk_out.sys_tick == clk_out.tx_tick)
    else $error("system tick not tied to transmit tick");
  chk_oe_needs_dir: assert property (!tio_q && !$past(tio_q) |-> !txc_pin_oe)
    else $error("clock pin driven with direction bit clear");
  chk_slot_marker: assert property (is5 && $past(is5, 2) && txc_pin_oe && clk_out.tx_en |-> !txc_pin_out)
    else $error("marker not low inside transmit window");
  chk_cts_stops: assert property (cts_gone |-> !clk_out.tx_en)
    else $error("transmit enabled with clear-to-send inactive");
  chk_en_plain: assert property (plain && $past(plain) |-> clk_out.rx_en && clk_out.tx_en)
    else $error("enables low in a plain clock mode");
  chk_rx_tick_lat: assert property (mode_q == 3'h0 && $rose(rxc_pin) |-> ##[3:5] clk_out.rx_tick)
    else $error("receive pin edge gave no tick");
  chk_rts_follow: assert property ($rose(rts_request) |=> rts)
    else $error("request-to-send did not follow request");
  chk_rts_drop: assert property (!rts_request |=> !rts)
    else $error("request-to-send active without request");
endmodule // scs_clock_select_monitor

bind scs_clock_select scs_clock_select_monitor u_monitor (
  .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rxc_pin,
  .txc_pin_out, .txc_pin_oe, .cts_pin, .rts_request, .rts, .clk_out);

// ==== tb/scs_line_model.sv ====
// Far-side clock, oscillator and frame sync sources
`timescale 1ns/10ps

module scs_line_model #(
  parameter int RX_HALF  = 4,
  parameter int TX_HALF  = 5,
  parameter int OSC_HALF = 3,
  parameter int FRAME    = 64
) (
  // Clock
  input wire logic clk,
  // Source enables
  input wire logic run_rx,
  input wire logic run_tx,
  input wire logic run_osc,
  // Pins
  output logic     rxc_pin,
  output logic     txc_pin_in,
  output logic     osc_pin,
  output logic     aux_pin
);
  int rx_c;
  int tx_c;
  int osc_c;
  int bit_c;

  // Sources idle low so the device sees no spurious edge at power-up
  initial {rxc_pin, txc_pin_in, osc_pin, aux_pin} = 4'h0;

  // Receive clock; sync rises with the first bit of each frame; stops only when low
  always @(posedge clk) begin
    if (!run_rx && !rxc_pin) begin
      rx_c <= 0;
      bit_c <= 0;
      aux_pin <= 1'b0;
    end else if (rx_c == RX_HALF - 1) begin
      rx_c <= 0;
      rxc_pin <= !rxc_pin;
      if (!rxc_pin) aux_pin <= (bit_c == 0);
      if (!rxc_pin) bit_c <= (bit_c + 1) % FRAME;
    end else begin
      rx_c <= rx_c + 1;
    end
  end

  // Transmit and oscillator clocks; receive to transmit ratio 1.25, below three
  always @(posedge clk) begin
    tx_c <= (!run_tx && !txc_pin_in || tx_c == TX_HALF - 1) ? 0 : tx_c + 1;
    txc_pin_in <= txc_pin_in ^ ((run_tx || txc_pin_in) && tx_c == TX_HALF - 1);
    osc_c <= (!run_osc && !osc_pin || osc_c == OSC_HALF - 1) ? 0 : osc_c + 1;
    osc_pin <= osc_pin ^ ((run_osc || osc_pin) && osc_c == OSC_HALF - 1);
  end
endmodule // scs_line_model

// ==== tb/scs_clock_select_tb_top.sv ====
// Self-checking bench for the clock select block
`timescale 1ns/10ps

module scs_clock_select_tb_top;
  logic                     clk = 1'b0;
  logic                     rst = 1'b1;
  logic [2:0]               reg_addr = 3'h0;
  logic [7:0]               reg_wdata = 8'h00;
  logic                     reg_wr = 1'b0;
  logic                     reg_rd = 1'b0;
  logic [7:0]               reg_rdata;
  logic                     rxc_pin, txc_pin_in, txc_pin_out, txc_pin_oe, aux_pin, osc_pin;
  logic                     rx_strobe_pin = 1'b1;
  logic                     tx_strobe_pin = 1'b1;
  logic                     cts_pin = 1'b1;
  logic                     rts_request = 1'b0;
  logic                     flag_penult = 1'b0;
  logic                     rts;
  logic                     run_rx = 1'b0;
  logic                     run_tx = 1'b0;
  logic                     run_osc = 1'b0;
  logic [31:0]              seed = 32'habfb;
  logic [5:0]               cur, prv;
  scs_pkg::scs_clk_out_type clk_out;
  int                       cyc, fails, cmp_count;
  int                       n [12];
  int                       s [12];
  int                       at [6];

  scs_clock_select dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxc_pin(rxc_pin), .txc_pin_in(txc_pin_in),
    .txc_pin_out(txc_pin_out), .txc_pin_oe(txc_pin_oe), .aux_pin(aux_pin),
    .osc_pin(osc_pin), .rx_strobe_pin(rx_strobe_pin), .tx_strobe_pin(tx_strobe_pin),
    .cts_pin(cts_pin), .rts_request(rts_request), .flag_penult(flag_penult),
    .rts(rts), .clk_out(clk_out));

  scs_line_model line (
    .clk(clk), .run_rx(run_rx), .run_tx(run_tx), .run_osc(run_osc), .rxc_pin(rxc_pin),
    .txc_pin_in(txc_pin_in), .osc_pin(osc_pin), .aux_pin(aux_pin));

  // 50 MHz clock
  always #10 clk = ~clk;

  // Model side: edges, ticks and window lengths counted every cycle
  assign cur = {rxc_pin, txc_pin_in, osc_pin, txc_pin_out, clk_out.rx_en, clk_out.tx_en};
  always @(posedge clk) begin
    cyc <= cyc + 1;
    prv <= cur;
    for (int i = 0; i < 6; i++) begin
      if (cur[i] && !prv[i]) n[i] <= n[i] + 1;
      if (cur[i] && !prv[i]) at[i] <= cyc;
    end
    n[6] <= n[6] + clk_out.rx_tick;
    n[7] <= n[7] + clk_out.tx_tick;
    n[8] <= n[8] + clk_out.sys_tick;
    n[9] <= n[9] + clk_out.rx_en;
    n[10] <= n[10] + clk_out.tx_en;
    n[11] <= n[11] + (txc_pin_oe && !txc_pin_out);
    if (cyc == 40000) begin
      fails++;
      conclude();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic int d(input int i);
    return n[i] - s[i];
  endfunction

  task automatic snap();
    s = n;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Write: one strobe cycle, then one idle cycle so strobes never collide
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  // Read: data taken at the edge that ends the answer cycle
  task automatic rdc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk("register", reg_rdata & m, exp & m);
  endtask

  task automatic wait_cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    logic [7:0]  rm [7];
    logic [31:0] v;
    int          m, f, b, w1, w2, prx, ptx;
    wait_cyc(20);
    rst <= 1'b0;
    @(posedge clk);
    for (int a = 0; a < 7; a++) rdc(3'(a), 8'hff, 8'h00);
    for (int a = 1; a < 7; a++) begin
      rm[a] = 8'(rnd());
      wr(3'(a), rm[a]);
    end
    wr(3'h7, 8'(rnd()));
    for (int a = 1; a < 7; a++) rdc(3'(a), 8'hff, rm[a]);
    for (int k = 0; k < 8; k++) begin
      wr(3'h0, 8'(k));
      rdc(3'h0, 8'h07, 8'(k));
      rdc(3'h7, 8'h07, 8'(k));
    end
    $display("test registers done");
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h00);
    snap();
    {run_rx, run_tx} <= 2'b11;
    wait_cyc(400);
    {run_rx, run_tx} <= 2'b00;
    wait_cyc(12);
    chk("rx ticks", d(6), d(5));
    chk("tx ticks", d(7), d(4));
    chk("sys ticks", d(8), d(4));
    $display("test external clocks done");
    wr(3'h0, 8'h01);
    snap();
    {run_rx, run_tx} <= 2'b11;
    wait_cyc(400);
    {run_rx, run_tx} <= 2'b00;
    wait_cyc(12);
    chk("strobe rx ticks", d(6), d(5));
    chk("strobe tx ticks", d(7), d(5));
    chk("tx strobe", d(0), d(4));
    chk("rx strobe", d(1), 1);
    $display("test strobes done");
    wr(3'h0, 8'h04);
    wr(3'h1, 8'h02);
    snap();
    run_osc <= 1'b1;
    wait_cyc(300);
    run_osc <= 1'b0;
    wait_cyc(12);
    chk("osc rx ticks", d(6), d(3));
    chk("osc tx ticks", d(7), d(3));
    chk("pin drive", txc_pin_oe, 1);
    chk("pin pulses", d(2), d(3));
    $display("test oscillator done");
    // Divider: settings 0 and 2 give factors 1 and 4 in each recovered-clock mode
    for (int k = 0; k < 8; k++) begin
      m = 2 + (k & 1) + ((k & 2) ? 4 : 0);
      f = (k & 4) ? 4 : 1;
      wr(3'h0, 8'(m));
      wr(3'h1, 8'h01);
      wr(3'h2, (k & 4) ? 8'h02 : 8'h00);
      snap();
      run_rx <= (m < 6);
      run_osc <= (m >= 6);
      wait_cyc(2560);
      {run_rx, run_osc} <= 2'b00;
      wait_cyc(12);
      b = ((m < 6) ? d(5) : d(3)) / (16 * f);
      chk("recovered ticks", d(6) >= b - 1 && d(6) <= b + 1, 1);
      chk("tx from recovered", d(7), d(6));
    end
    $display("test divider modes done");
    // Time slots with random positions and widths
    v = rnd();
    prx = 2 * v[2:0] + v[6];
    ptx = 2 * (v[2:0] + 1 + v[5:3]) + v[7];
    w1 = v[10:8];
    w2 = v[13:11];
    wr(3'h0, 8'h05);
    wr(3'h1, {4'h0, v[7], v[6], 2'b10});
    wr(3'h3, 8'(w1)); // not transparent, so any width
    wr(3'h4, 8'(w2));
    wr(3'h5, 8'(v[2:0]));
    wr(3'h6, 8'(v[2:0] + 1 + v[5:3]));
    rts_request <= 1'b1;
    flag_penult <= 1'b1;
    wait_cyc(4);
    chk("rts raised", rts, 1);
    snap();
    run_rx <= 1'b1;
    wait_cyc(1024);
    chk("rx window", d(9), 16 * (w1 + 1));
    chk("tx window", d(10), 16 * (w2 + 1));
    chk("slot spacing", at[0] - at[1], 8 * (ptx - prx));
    chk("window marker", d(11), 16 * (w2 + 1));
    chk("rts released", rts, 0); // rts gates no driver here
    {rx_strobe_pin, tx_strobe_pin} <= 2'b00;
    snap();
    wait_cyc(512);
    chk("strobed rx window", d(9), 0);
    chk("strobed tx window", d(10), 0);
    {rx_strobe_pin, tx_strobe_pin, cts_pin} <= 3'b110;
    snap();
    wait_cyc(512);
    chk("rx window again", d(9), 8 * (w1 + 1));
    chk("cts tx window", d(10), 0);
    run_rx <= 1'b0;
    rts_request <= 1'b0;
    wait_cyc(3);
    chk("rts idle", rts, 0);
    $display("test time slots done");
    conclude();
  end
endmodule // scs_clock_select_tb_top
